// *** hdl/i2stx_pkg.sv ***
package i2stx_pkg;

   // Register byte offsets on the APB bus
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] FRAMES_OFS   = 8'h04;
   localparam logic [7:0] BASE_OFS     = 8'h08;
   localparam logic [7:0] STATUS_OFS   = 8'h0c;
   localparam logic [7:0] MASK_OFS     = 8'h10;
   localparam logic [7:0] STATE_OFS    = 8'h14;
   localparam logic [7:0] RAM_PTR_OFS  = 8'h18;
   localparam logic [7:0] RAM_DATA_OFS = 8'h1c;

   // Control field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_ABORT_BIT = 1;

   // Status and mask layout
   localparam int STS_W          = 3;
   localparam int STS_LEFT_END   = 0;
   localparam int STS_RIGHT_END  = 1;
   localparam int STS_OVERRUN    = 2;
   localparam logic [2:0] MASK_RST = 3'h0;

   // Sample format and channel indices
   localparam int SAMPLE_W     = 32;
   localparam int SAMPLE_BYTES = 4;
   localparam int BITCNT_W     = 6;
   localparam int LEFT_CH      = 0;
   localparam int RIGHT_CH     = 1;

   // Descriptor engine states, Gray along the chain
   typedef enum logic [2:0] {
      ENG_IDLE = 3'h0,
      ENG_DIS  = 3'h1,
      ENG_ENA  = 3'h3,
      ENG_DATA = 3'h2,
      ENG_ADDR = 3'h6,
      ENG_ENDP = 3'h7
   } i2stx_eng_t;

endpackage : i2stx_pkg

// *** hdl/i2stx_slave.sv ***
`timescale 1ns/10ps
module i2stx_slave (
   input  wire logic        clk,         // System clock
   input  wire logic        rstn,        // Async reset, active low
   input  wire logic        sck_fall,    // Bit clock falling edge pulse
   input  wire logic        active,      // Strobe says this slave is on
   input  wire logic        enable,      // Function enable bit
   input  wire logic        load,        // Transmit buffer write pulse
   input  wire logic [31:0] load_data,   // Transmit buffer write data
   output logic             sdo,         // Serial data out
   output logic             sdo_oe       // Drive enable for serial data
);

   logic [31:0]                      buf_ff;
   logic [31:0]                      shreg_ff;
   logic [i2stx_pkg::BITCNT_W-1:0]   bitcnt_ff;
   logic                             started_ff;

   // Transmit buffer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         buf_ff <= 32'h0;
      end else if (!enable) begin
         buf_ff <= 32'h0;
      end else if (load) begin
         buf_ff <= load_data;
      end
   end

   // Drive only while enabled and selected
   // idle output undriven
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sdo_oe <= 1'b0;
      end else begin
         sdo_oe <= enable & active;
      end
   end

   // Shift out MSB first on falling bit clock edges
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shreg_ff   <= 32'h0;
         bitcnt_ff  <= '0;
         started_ff <= 1'b0;
         sdo        <= 1'b0;
      end else if (!enable || !active) begin
         started_ff <= 1'b0;
         bitcnt_ff  <= '0;
         sdo        <= 1'b0;
      end else if (sck_fall) begin
         if (!started_ff) begin
            sdo        <= buf_ff[31];
            shreg_ff   <= {buf_ff[30:0], 1'b0};
            bitcnt_ff  <= i2stx_pkg::BITCNT_W'(1);
            started_ff <= 1'b1;
         end else if (bitcnt_ff < i2stx_pkg::BITCNT_W'(i2stx_pkg::SAMPLE_W))
         begin
            sdo       <= shreg_ff[31];
            shreg_ff  <= {shreg_ff[30:0], 1'b0};
            bitcnt_ff <= bitcnt_ff + i2stx_pkg::BITCNT_W'(1);
         end else begin
            sdo <= 1'b0;
         end
      end
   end

endmodule : i2stx_slave

// *** hdl/i2stx_chain.sv ***
`timescale 1ns/10ps
module i2stx_chain #(
   parameter int RAM_WORDS = 256,        // Sample memory depth in words
   parameter int CNT_W     = 16          // Frame counter width
) (
   input  wire logic        pclk,        // APB clock, 40 MHz
   input  wire logic        presetn,     // Async reset, active low
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB access phase
   input  wire logic        pwrite,      // APB write
   input  wire logic [7:0]  paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output logic      [31:0] prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr,     // APB error on unmapped address
   input  wire logic        sck_pin,     // Bit clock from pin
   input  wire logic        strobe_pin,  // Channel strobe from pin
   output logic             left_sdo,    // Left slave serial data
   output logic             left_sdo_oe, // Left slave drive enable
   output logic             right_sdo,   // Right slave serial data
   output logic             right_sdo_oe,// Right slave drive enable
   output logic             irq          // Interrupt, active high level
);

   localparam int AW = $clog2(RAM_WORDS);
   localparam int SW = AW + 2;

   // Refuse shapes the logic cannot serve
   generate
      if (RAM_WORDS < 2 || (1 << AW) != RAM_WORDS) begin : g_bad_depth
         $error("RAM_WORDS must be a power of two, at least 2");
      end
      if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
         $error("CNT_W must lie between 2 and 32");
      end
   endgenerate

   logic [2:0]                 sck_sync_ff;
   logic [2:0]                 strb_sync_ff;
   logic                       sck_fall;
   logic                       strb_rise;
   logic                       strb_fall;
   logic [31:0]                ram_mem [RAM_WORDS];
   logic [AW-1:0]              ram_ptr_ff;
   logic [CNT_W-1:0]           frames_ff;
   logic [SW-1:0]              base_ff;
   logic [i2stx_pkg::STS_W-1:0] sts_ff;
   logic [i2stx_pkg::STS_W-1:0] mask_ff;
   logic [i2stx_pkg::STS_W-1:0] sts_set;
   logic                       pready_ff;
   logic                       acc_go;
   logic                       wr_go;
   logic                       rd_sts_go;
   logic                       start_go;
   logic                       abort_go;
   i2stx_pkg::i2stx_eng_t      state_ff;
   logic                       ch_ff;
   logic [1:0]                 pend_ff;
   logic [1:0]                 armed_ff;
   logic [1:0]                 spe_ff;
   logic [1:0]                 dis_chain_ff;
   logic [1:0]                 load_ff;
   logic [31:0]                ld_data_ff;
   logic [CNT_W-1:0]           cnt_ff [2];
   logic [SW-1:0]              src_ff [2];
   logic [1:0]                 trig;
   logic                       take;
   logic                       take_ch;
   logic [CNT_W-1:0]           nxt_cnt;
   logic                       cnt_end;
   logic [SW-1:0]              nxt_src;

   // Two-stage synchronisers plus edge stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_sync_ff  <= 3'h7;
         strb_sync_ff <= 3'h7;
      end else begin
         sck_sync_ff  <= {sck_sync_ff[1:0], sck_pin};
         strb_sync_ff <= {strb_sync_ff[1:0], strobe_pin};
      end
   end

   assign sck_fall  = sck_sync_ff[2] & ~sck_sync_ff[1];
   assign strb_rise = ~strb_sync_ff[2] & strb_sync_ff[1];
   assign strb_fall = strb_sync_ff[2] & ~strb_sync_ff[1];

   assign trig[i2stx_pkg::LEFT_CH]  = strb_rise & armed_ff[0];
   assign trig[i2stx_pkg::RIGHT_CH] = strb_fall & armed_ff[1];

   // APB handshake: no wait states, data from flops
   assign acc_go    = psel & penable & pready_ff;
   assign wr_go     = acc_go & pwrite;
   assign rd_sts_go = acc_go & ~pwrite & (paddr == i2stx_pkg::STATUS_OFS);
   assign start_go  = wr_go & (paddr == i2stx_pkg::CTRL_OFS)
                      & pwdata[i2stx_pkg::CTRL_START_BIT] & ~(|armed_ff);
   assign abort_go  = wr_go & (paddr == i2stx_pkg::CTRL_OFS)
                      & pwdata[i2stx_pkg::CTRL_ABORT_BIT];

   // Ready pulse for the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= psel & ~penable;
      end
   end

   assign pready = pready_ff;

   // Read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= 1'b0;
         prdata  <= 32'h0;
         if (paddr == i2stx_pkg::CTRL_OFS) begin
            prdata <= 32'h0;
         end else if (paddr == i2stx_pkg::FRAMES_OFS) begin
            prdata <= 32'(frames_ff);
         end else if (paddr == i2stx_pkg::BASE_OFS) begin
            prdata <= 32'(base_ff);
         end else if (paddr == i2stx_pkg::STATUS_OFS) begin
            prdata <= 32'(sts_ff);
         end else if (paddr == i2stx_pkg::MASK_OFS) begin
            prdata <= 32'(mask_ff);
         end else if (paddr == i2stx_pkg::STATE_OFS) begin
            prdata <= {16'h0, 8'(cnt_ff[0]), 1'b0,
                       (state_ff != i2stx_pkg::ENG_IDLE),
                       dis_chain_ff, armed_ff, spe_ff};
         end else if (paddr == i2stx_pkg::RAM_PTR_OFS) begin
            prdata <= 32'(ram_ptr_ff);
         end else if (paddr == i2stx_pkg::RAM_DATA_OFS) begin
            prdata <= ram_mem[ram_ptr_ff];
         end else begin
            pslverr <= 1'b1;
         end
      end
   end

   // Software configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frames_ff <= '0;
         base_ff   <= '0;
         mask_ff   <= i2stx_pkg::MASK_RST;
      end else if (wr_go) begin
         if (paddr == i2stx_pkg::FRAMES_OFS) begin
            frames_ff <= pwdata[CNT_W-1:0];
         end else if (paddr == i2stx_pkg::BASE_OFS) begin
            base_ff <= {pwdata[SW-1:2], 2'b00};
         end else if (paddr == i2stx_pkg::MASK_OFS) begin
            mask_ff <= pwdata[i2stx_pkg::STS_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ram_ptr_ff <= '0;
      end else if (wr_go && paddr == i2stx_pkg::RAM_PTR_OFS) begin
         ram_ptr_ff <= pwdata[AW-1:0];
      end else if (acc_go && paddr == i2stx_pkg::RAM_DATA_OFS) begin
         ram_ptr_ff <= ram_ptr_ff + AW'(1);
      end
   end

   always_ff @(posedge pclk) begin
      if (wr_go && paddr == i2stx_pkg::RAM_DATA_OFS) begin
         ram_mem[ram_ptr_ff] <= pwdata;
      end
   end

   // Sticky status, read clears, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_ff <= '0;
         irq    <= 1'b0;
      end else begin
         sts_ff <= (sts_ff & ~{i2stx_pkg::STS_W{rd_sts_go}}) | sts_set;
         irq    <= |(((sts_ff & ~{i2stx_pkg::STS_W{rd_sts_go}}) | sts_set)
                     & mask_ff);
      end
   end

   // Status events from the engine and trigger overrun
   always_comb begin
      sts_set = '0;
      sts_set[i2stx_pkg::STS_OVERRUN] = |(trig & pend_ff);
      if (state_ff == i2stx_pkg::ENG_DIS && !dis_chain_ff[ch_ff]) begin
         sts_set[i2stx_pkg::STS_LEFT_END]  = ~ch_ff;
         sts_set[i2stx_pkg::STS_RIGHT_END] = ch_ff;
      end
   end

   // Pending triggers, left before right when both wait
   assign take    = (state_ff == i2stx_pkg::ENG_IDLE) & (|pend_ff);
   assign take_ch = ~pend_ff[0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff <= 2'b00;
      end else if (abort_go || start_go) begin
         pend_ff <= 2'b00;
      end else begin
         pend_ff <= (pend_ff & ~({1'b0, take} << take_ch)) | trig;
      end
   end

   // Descriptor engine sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= i2stx_pkg::ENG_IDLE;
         ch_ff    <= 1'b0;
      end else if (abort_go) begin
         state_ff <= i2stx_pkg::ENG_IDLE;
      end else begin
         case (state_ff)
            i2stx_pkg::ENG_IDLE: begin
               if (take) begin
                  ch_ff    <= take_ch;
                  state_ff <= i2stx_pkg::ENG_DIS;
               end
            end
            i2stx_pkg::ENG_DIS: begin
               state_ff <= dis_chain_ff[ch_ff] ? i2stx_pkg::ENG_ENA
                                               : i2stx_pkg::ENG_IDLE;
            end
            i2stx_pkg::ENG_ENA: begin
               state_ff <= i2stx_pkg::ENG_DATA;
            end
            i2stx_pkg::ENG_DATA: begin
               state_ff <= i2stx_pkg::ENG_ADDR;
            end
            i2stx_pkg::ENG_ADDR: begin
               state_ff <= cnt_end ? i2stx_pkg::ENG_ENDP
                                   : i2stx_pkg::ENG_IDLE;
            end
            default: begin
               state_ff <= i2stx_pkg::ENG_IDLE;
            end
         endcase
      end
   end

   // Function enable bits of both slaves
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spe_ff <= 2'b00;
      end else if (abort_go) begin
         spe_ff <= 2'b00;
      end else if (state_ff == i2stx_pkg::ENG_DIS) begin
         spe_ff[ch_ff] <= 1'b0;
      end else if (state_ff == i2stx_pkg::ENG_ENA) begin
         spe_ff[ch_ff] <= 1'b1;
      end
   end

   // Armed channels accept strobe triggers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_ff <= 2'b00;
      end else if (abort_go) begin
         armed_ff <= 2'b00;
      end else if (start_go) begin
         armed_ff <= 2'b11;
      end else if (state_ff == i2stx_pkg::ENG_DIS && !dis_chain_ff[ch_ff])
      begin
         armed_ff[ch_ff] <= 1'b0;
      end
   end

   // Transmit buffer load from sample memory
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_ff    <= 2'b00;
         ld_data_ff <= 32'h0;
      end else begin
         load_ff <= 2'b00;
         if (state_ff == i2stx_pkg::ENG_DATA) begin
            load_ff[ch_ff] <= 1'b1;
            ld_data_ff     <= ram_mem[src_ff[ch_ff][SW-1:2]];
         end
      end
   end

   assign nxt_cnt = cnt_ff[ch_ff] - CNT_W'(1);
   assign cnt_end = (cnt_ff[ch_ff] == '0) | (nxt_cnt == '0);
   assign nxt_src = src_ff[ch_ff] + SW'(i2stx_pkg::SAMPLE_BYTES);

   // Descriptor contents: counters, addresses, chain enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dis_chain_ff <= 2'b00;
         cnt_ff[0]    <= '0;
         cnt_ff[1]    <= '0;
         src_ff[0]    <= '0;
         src_ff[1]    <= '0;
      end else if (start_go) begin
         dis_chain_ff <= 2'b11;
         cnt_ff[i2stx_pkg::LEFT_CH]  <= frames_ff - CNT_W'(1);
         cnt_ff[i2stx_pkg::RIGHT_CH] <= frames_ff;
         src_ff[i2stx_pkg::LEFT_CH]  <= base_ff;
         src_ff[i2stx_pkg::RIGHT_CH] <= base_ff
                                        + SW'(i2stx_pkg::SAMPLE_BYTES);
      end else if (state_ff == i2stx_pkg::ENG_ADDR) begin
         src_ff[~ch_ff] <= nxt_src;
         if (!cnt_end) begin
            cnt_ff[ch_ff] <= nxt_cnt;
         end else begin
            cnt_ff[ch_ff] <= '0;
         end
      end else if (state_ff == i2stx_pkg::ENG_ENDP) begin
         dis_chain_ff[ch_ff] <= 1'b0;
      end
   end

   i2stx_slave u_left_serial_slave (
      .clk       (pclk),
      .rstn      (presetn),
      .sck_fall  (sck_fall),
      .active    (~strb_sync_ff[1]),
      .enable    (spe_ff[i2stx_pkg::LEFT_CH]),
      .load      (load_ff[i2stx_pkg::LEFT_CH]),
      .load_data (ld_data_ff),
      .sdo       (left_sdo),
      .sdo_oe    (left_sdo_oe)
   );

   i2stx_slave u_right_serial_slave (
      .clk       (pclk),
      .rstn      (presetn),
      .sck_fall  (sck_fall),
      .active    (strb_sync_ff[1]),
      .enable    (spe_ff[i2stx_pkg::RIGHT_CH]),
      .load      (load_ff[i2stx_pkg::RIGHT_CH]),
      .load_data (ld_data_ff),
      .sdo       (right_sdo),
      .sdo_oe    (right_sdo_oe)
   );

endmodule : i2stx_chain

// *** verification/i2stx_chain_asserts.sv ***
`timescale 1ns/10ps
module i2stx_chain_asserts (
   input wire logic        pclk,         // Clock
   input wire logic        presetn,      // Reset
   input wire logic        psel,         // Select
   input wire logic        penable,      // Access phase
   input wire logic        pwrite,       // Write
   input wire logic [7:0]  paddr,        // Address
   input wire logic [31:0] pwdata,       // Write data
   input wire logic [31:0] prdata,       // Read data
   input wire logic        pready,       // Ready
   input wire logic        pslverr,      // Error
   input wire logic        sck_pin,      // Bit clock
   input wire logic        strobe_pin,   // Channel strobe
   input wire logic        left_sdo,     // Left data
   input wire logic        left_sdo_oe,  // Left enable
   input wire logic        right_sdo,    // Right data
   input wire logic        right_sdo_oe, // Right enable
   input wire logic        irq           // Interrupt
);
   logic clr_acc;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Accesses that may lower the interrupt
   assign clr_acc = psel && penable && pready &&
      (pwrite ? paddr != i2stx_pkg::STATUS_OFS
              : paddr == i2stx_pkg::STATUS_OFS);

   // Steps shared by the properties
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_hi5;
      strobe_pin [*5];
   endsequence
   sequence s_lo5;
      !strobe_pin [*5];
   endsequence

   a_ready_after_setup:
      assert property (s_setup |=> pready && penable)
      else $error("ready missing after setup");
   a_ready_one_cycle:
      assert property (pready |=> !pready)
      else $error("ready held too long");
   a_unmapped_error:
      assert property (pready && paddr > i2stx_pkg::RAM_DATA_OFS |-> pslverr)
      else $error("unmapped access without error");
   a_error_reads_zero:
      assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_left_idle_high:
      assert property (s_hi5 |-> !left_sdo_oe)
      else $error("left drives while strobe high");
   a_right_idle_low:
      assert property (s_lo5 |-> !right_sdo_oe)
      else $error("right drives while strobe low");
   a_oe_rise_strobe:
      assert property ($rose(left_sdo_oe) |->
         !$past(strobe_pin) && !$past(strobe_pin, 2))
      else $error("left enable rose with strobe high");
   a_sdo_on_fall:
      assert property ((left_sdo_oe && $past(left_sdo_oe) && $changed(left_sdo))
         || (right_sdo_oe && $past(right_sdo_oe) && $changed(right_sdo))
         |-> !$past(sck_pin))
      else $error("data changed away from clock fall");
   a_idle_sdo_low:
      assert property (!(left_sdo && !left_sdo_oe)
         && !(right_sdo && !right_sdo_oe))
      else $error("data high on undriven line");
   a_irq_fall_cause:
      assert property ($fell(irq) |-> $past(clr_acc) || $past(clr_acc, 2))
      else $error("interrupt dropped without access");
endmodule : i2stx_chain_asserts

bind i2stx_chain i2stx_chain_asserts chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sck_pin(sck_pin),
   .strobe_pin(strobe_pin), .left_sdo(left_sdo),
   .left_sdo_oe(left_sdo_oe), .right_sdo(right_sdo),
   .right_sdo_oe(right_sdo_oe), .irq(irq)
);

// *** verification/i2stx_rx_model.sv ***
`timescale 1ns/10ps
module i2stx_rx_model (
   output logic      sck_pin,      // Bit clock, idles high
   output logic      strobe_pin,   // Channel strobe
   input  wire logic left_sdo,     // Left data
   input  wire logic left_sdo_oe,  // Left enable
   input  wire logic right_sdo,    // Right data
   input  wire logic right_sdo_oe  // Right enable
);
   logic        ws;
   logic        armed;
   logic [31:0] sh;
   logic [31:0] left_q[$];
   logic [31:0] right_q[$];
   wire         sd;

   assign sd = (left_sdo_oe & left_sdo) | (right_sdo_oe & right_sdo);

   // Idle levels, clock stands still between runs
   initial begin
      sck_pin    = 1'b1;
      strobe_pin = 1'b1;
      ws         = 1'b1;
   end

   // one bit, half period low then high
   task automatic step(input logic slot_end, input logic nws);
      logic pws;
      pws     = ws;
      sck_pin = 1'b0;
      ws      = nws;
      #100;
      sck_pin = 1'b1;
      sh      = {sh[30:0], sd};
      // word latched by word select level
      if (slot_end && armed) begin
         if (pws) begin
            right_q.push_back(sh);
         end else begin
            left_q.push_back(sh);
         end
      end
      if (slot_end) begin
         strobe_pin = ws;
         armed      = 1'b1;
      end
      #100;
   endtask : step

   // Frames of left then right slots, plus a closing bit
   task automatic run(input int nf);
      left_q.delete();
      right_q.delete();
      armed = 1'b0;
      #7;
      for (int s = 0; s < 2 * nf; s++) begin
         for (int j = 0; j < 32; j++) begin
            step(j == 0, (j == 0) ? s[0] : ws);
         end
      end
      step(1'b1, ws);
   endtask : run
endmodule : i2stx_rx_model

// *** verification/i2stx_chain_tb.sv ***
`timescale 1ns/10ps
module i2stx_chain_tb;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, sck_pin, strobe_pin;
   logic        left_sdo, left_sdo_oe, right_sdo, right_sdo_oe;
   int          bad_count = 0;
   int          n_tests   = 0;

   // Bus clock, 25 ns period
   always #12.5 pclk = ~pclk;

   i2stx_chain dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck_pin(sck_pin), .strobe_pin(strobe_pin),
      .left_sdo(left_sdo), .left_sdo_oe(left_sdo_oe),
      .right_sdo(right_sdo), .right_sdo_oe(right_sdo_oe), .irq(irq));

   i2stx_rx_model rx_u (.sck_pin(sck_pin), .strobe_pin(strobe_pin),
      .left_sdo(left_sdo), .left_sdo_oe(left_sdo_oe),
      .right_sdo(right_sdo), .right_sdo_oe(right_sdo_oe));

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   // One bus transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         bad_count++;
         complete_run();
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   function automatic logic [31:0] ram_word(input int i);
      return 32'hc3a5_0001 + (32'(i) << 20);
   endfunction : ram_word

   // Received words against sample indices, negative means silence
   task automatic check_ch(input logic [31:0] got[$], input int idx[$]);
      chk(32'(got.size()), 32'(idx.size())); // one word per slot
      foreach (idx[i]) begin
         chk(got[i], idx[i] < 0 ? 32'h0 : ram_word(idx[i])); // order
      end
   endtask : check_ch

   task automatic run_case(input int n, input int base, input int mask,
                           input int nf, input int li[$], input int ri[$]);
      wr(i2stx_pkg::CTRL_OFS, 32'h1 << i2stx_pkg::CTRL_ABORT_BIT);
      wr(i2stx_pkg::FRAMES_OFS, 32'(n));
      wr(i2stx_pkg::BASE_OFS, 32'(base));
      wr(i2stx_pkg::MASK_OFS, 32'(mask));
      wr(i2stx_pkg::CTRL_OFS, 32'h1 << i2stx_pkg::CTRL_START_BIT);
      rx_u.run(nf);
      check_ch(rx_u.left_q, li);  // left slot
      check_ch(rx_u.right_q, ri); // right slot
   endtask : run_case

   task automatic status_clears;
      logic [31:0] d;
      logic        e;
      apb(1'b0, i2stx_pkg::STATUS_OFS, 32'h0, d, e);
      chk(d, 32'h3); // both channels ended
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
   endtask : status_clears

   task automatic test_regs;
      logic [31:0] d;
      logic        e;
      apb(1'b0, i2stx_pkg::MASK_OFS, 32'h0, d, e);
      chk(d, 32'(i2stx_pkg::MASK_RST));
      apb(1'b0, 8'h20, 32'h0, d, e);
      chk(d, 32'h0);
      chk({31'h0, e}, 32'h1);
      wr(i2stx_pkg::RAM_PTR_OFS, 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr(i2stx_pkg::RAM_DATA_OFS, ram_word(i));
      end
      $display("test_regs done at %0t", $time);
   endtask : test_regs

   task automatic test_stream;
      run_case(3, 0, 3, 4, '{-1, 2, 4, -1}, '{1, 3, 5, -1});
      chk({31'h0, irq}, 32'h1); // end raised
      status_clears();
      $display("test_stream done at %0t", $time);
   endtask : test_stream

   task automatic test_masked;
      run_case(2, 8, 0, 3, '{-1, 4, -1}, '{3, 5, -1});
      chk({31'h0, irq}, 32'h0);
      wr(i2stx_pkg::MASK_OFS, 32'h3);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      status_clears();
      $display("test_masked done at %0t", $time);
   endtask : test_masked

   task automatic test_abort;
      run_case(3, 0, 0, 1, '{-1}, '{1}); // first pair
      wr(i2stx_pkg::CTRL_OFS, 32'h1 << i2stx_pkg::CTRL_ABORT_BIT);
      rx_u.run(1);
      check_ch(rx_u.left_q, '{-1});  // stopped slave silent
      check_ch(rx_u.right_q, '{-1}); // disable clears state
      $display("test_abort done at %0t", $time);
   endtask : test_abort

   // Reset, then the scenarios in turn
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      test_regs();
      test_stream();
      test_masked();
      test_abort();
      complete_run();
   end
endmodule : i2stx_chain_tb
